/* rtl/cioc_pkg.sv */
// package: register map, field layouts and timing constants of the channel i/o conditioning block
package cioc_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int BREAK_DELAY_MS = 100;
  localparam int BREAK_DELAY_CYC = (CLK_HZ / 1000) * BREAK_DELAY_MS;
  localparam int SSI_RATE_HZ = 300000;
  localparam int SSI_HALF_CYC = CLK_HZ / (2 * SSI_RATE_HZ);
  localparam int PWM_RATE_HZ = 1000;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_RATE_HZ;
  localparam int AIN_N = 4;
  localparam int AIN_LO_BITS = 10;
  localparam int AIN_HI_BITS = 16;
  localparam int DOUT_N = 4;
  localparam int DIN_N = 4;
  localparam int ISIG_N = 4;
  localparam int CH_N = 2;

  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_IRQ_EN = 8'h08;
  localparam logic [7:0] A_IRQ_CLR = 8'h0C;
  localparam logic [7:0] A_FILT = 8'h10;
  localparam logic [7:0] A_BRK_CMD = 8'h14;
  localparam logic [7:0] A_BRK_FB = 8'h18;
  localparam logic [7:0] A_ROUTE = 8'h1C;
  localparam logic [7:0] A_DOUT = 8'h20;
  localparam logic [7:0] A_SOL0 = 8'h24;
  localparam logic [7:0] A_SOL1 = 8'h28;
  localparam logic [7:0] A_REM_CMD = 8'h2C;
  localparam logic [7:0] A_AIN01 = 8'h30;
  localparam logic [7:0] A_AIN23 = 8'h34;
  localparam logic [7:0] A_SSI = 8'h38;

  // control register fields
  localparam int C_REMOTE = 0;
  localparam int C_CH_EN0 = 1;
  localparam int C_BRK_ON_CMD = 3;
  localparam int C_BRK_ON_FB = 4;
  localparam int C_ACT_CMD = 5;
  localparam int C_ACT_FB = 6;
  localparam int C_CURMEAS = 7;
  localparam int C_CLOSED = 8;
  localparam int C_AOSEL_LSB = 9;
  localparam int C_TYPE_CMD_LSB = 12;
  localparam int C_TYPE_FB_LSB = 15;
  // status fields
  localparam int S_ERR_CMD = 0;
  localparam int S_ERR_FB = 1;
  localparam int S_SSI_DONE = 2;

  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    CIOC_SIG_OFF = 3'h0, CIOC_SIG_VOLT = 3'h1, CIOC_SIG_CURR = 3'h2,
    CIOC_SIG_FREQ = 3'h3, CIOC_SIG_PWM = 3'h4
  } cioc_sig_t;

  typedef enum logic [1:0] {
    CIOC_AO_DRV = 2'h0, CIOC_AO_CMD = 2'h1, CIOC_AO_FB = 2'h2, CIOC_AO_DEV = 2'h3
  } cioc_aosel_t;

  typedef enum logic [1:0] {
    CIOC_SSI_IDLE = 2'b00, CIOC_SSI_SHIFT = 2'b01, CIOC_SSI_PAUSE = 2'b11
  } cioc_ssi_t;

  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
  } cioc_lim_t;
endpackage

/* rtl/cioc_top.sv */
// channel i/o conditioning: filtered analogue inputs, break check, ssi, pwm, digital i/o
`timescale 1ns/1ps
`default_nettype none
module cioc_top #(
  parameter int BRK_CYC = cioc_pkg::BREAK_DELAY_CYC,
  parameter int PWM_CYC = cioc_pkg::PWM_PERIOD_CYC,
  parameter int SSI_BITS = 24
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [9:0]  ain0,
  input  wire logic [9:0]  ain1,
  input  wire logic [15:0] ain2,
  input  wire logic [15:0] ain3,
  input  wire logic        ain_strobe,
  input  wire logic [3:0]  din,
  input  wire logic [15:0] sol_cur0,
  input  wire logic [15:0] sol_cur1,
  input  wire logic        ssi_data,
  output logic             ssi_clk,
  output logic [1:0]       sol_pwm,
  output logic [3:0]       dout,
  output logic [15:0]      aout,
  output logic [1:0]       ch_din,
  output logic [15:0]      ch_cmd,
  output logic [15:0]      ch_fb,
  output logic             irq
);
  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  logic [31:0] ctrl_r, filt_r, route_r, dout_r, sol0_r, sol1_r, remcmd_r;
  cioc_pkg::cioc_lim_t brk_cmd_r, brk_fb_r;
  logic [2:0]  stat_r, irq_en_r;
  logic        aw_ok_r, w_ok_r;
  logic [7:0]  awa_r;
  logic [31:0] wd_r;
  logic [15:0] filt_q [4];
  logic [SSI_BITS-1:0] ssi_pos_r;
  logic [2:0]  ev_set;
  logic        wr_go;
  logic        wr_hit;

  assign s_axi_awready = !aw_ok_r && !s_axi_bvalid;
  assign s_axi_wready = !w_ok_r && !s_axi_bvalid;
  assign wr_go = aw_ok_r && w_ok_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      awa_r <= 8'h00;
      wd_r <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_r <= 1'b1;
        awa_r <= s_axi_awaddr[7:0];
      end else if (wr_go) begin
        aw_ok_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_r <= 1'b1;
        wd_r <= s_axi_wdata;
      end else if (wr_go) begin
        w_ok_r <= 1'b0;
      end
    end
  end

  always_comb begin
    if (awa_r == cioc_pkg::A_CTRL || awa_r == cioc_pkg::A_IRQ_EN
        || awa_r == cioc_pkg::A_IRQ_CLR || awa_r == cioc_pkg::A_FILT
        || awa_r == cioc_pkg::A_BRK_CMD || awa_r == cioc_pkg::A_BRK_FB
        || awa_r == cioc_pkg::A_ROUTE || awa_r == cioc_pkg::A_DOUT
        || awa_r == cioc_pkg::A_SOL0 || awa_r == cioc_pkg::A_SOL1
        || awa_r == cioc_pkg::A_REM_CMD) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cioc_pkg::RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? cioc_pkg::RESP_OK : cioc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // writes ignore wstrb: every register is taken as a whole word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= cioc_pkg::CTRL_RST;
      irq_en_r <= 3'h0;
      filt_r <= 32'h0000_0000;
      brk_cmd_r <= '0;
      brk_fb_r <= '0;
      route_r <= 32'h0000_0000;
      dout_r <= 32'h0000_0000;
      sol0_r <= 32'h0000_0000;
      sol1_r <= 32'h0000_0000;
      remcmd_r <= 32'h0000_0000;
    end else if (wr_go) begin
      if (awa_r == cioc_pkg::A_CTRL) begin
        ctrl_r <= wd_r;
      end else if (awa_r == cioc_pkg::A_IRQ_EN) begin
        irq_en_r <= wd_r[2:0];
      end else if (awa_r == cioc_pkg::A_FILT) begin
        filt_r <= wd_r;
      end else if (awa_r == cioc_pkg::A_BRK_CMD) begin
        brk_cmd_r <= wd_r;
      end else if (awa_r == cioc_pkg::A_BRK_FB) begin
        brk_fb_r <= wd_r;
      end else if (awa_r == cioc_pkg::A_ROUTE) begin
        route_r <= wd_r;
      end else if (awa_r == cioc_pkg::A_DOUT) begin
        dout_r <= wd_r;
      end else if (awa_r == cioc_pkg::A_SOL0) begin
        sol0_r <= wd_r;
      end else if (awa_r == cioc_pkg::A_SOL1) begin
        sol1_r <= wd_r;
      end else if (awa_r == cioc_pkg::A_REM_CMD) begin
        remcmd_r <= wd_r;
      end
    end
  end

  // status: set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= 3'h0;
    end else if (wr_go && awa_r == cioc_pkg::A_IRQ_CLR) begin
      stat_r <= (stat_r & ~wd_r[2:0]) | ev_set;
    end else begin
      stat_r <= stat_r | ev_set;
    end
  end
  assign irq = |(stat_r & irq_en_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cioc_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= cioc_pkg::RESP_OK;
      if (s_axi_araddr[7:0] == cioc_pkg::A_CTRL) begin
        s_axi_rdata <= ctrl_r;
      end else if (s_axi_araddr[7:0] == cioc_pkg::A_STAT) begin
        s_axi_rdata <= {29'h0, stat_r};
      end else if (s_axi_araddr[7:0] == cioc_pkg::A_IRQ_EN) begin
        s_axi_rdata <= {29'h0, irq_en_r};
      end else if (s_axi_araddr[7:0] == cioc_pkg::A_IRQ_CLR) begin
        s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_araddr[7:0] == cioc_pkg::A_FILT) begin
        s_axi_rdata <= filt_r;
      end else if (s_axi_araddr[7:0] == cioc_pkg::A_BRK_CMD) begin
        s_axi_rdata <= brk_cmd_r;
      end else if (s_axi_araddr[7:0] == cioc_pkg::A_BRK_FB) begin
        s_axi_rdata <= brk_fb_r;
      end else if (s_axi_araddr[7:0] == cioc_pkg::A_ROUTE) begin
        s_axi_rdata <= route_r;
      end else if (s_axi_araddr[7:0] == cioc_pkg::A_DOUT) begin
        s_axi_rdata <= dout_r;
      end else if (s_axi_araddr[7:0] == cioc_pkg::A_SOL0) begin
        s_axi_rdata <= sol0_r;
      end else if (s_axi_araddr[7:0] == cioc_pkg::A_SOL1) begin
        s_axi_rdata <= sol1_r;
      end else if (s_axi_araddr[7:0] == cioc_pkg::A_REM_CMD) begin
        s_axi_rdata <= remcmd_r;
      end else if (s_axi_araddr[7:0] == cioc_pkg::A_AIN01) begin
        s_axi_rdata <= {filt_q[1], filt_q[0]};
      end else if (s_axi_araddr[7:0] == cioc_pkg::A_AIN23) begin
        s_axi_rdata <= {filt_q[3], filt_q[2]};
      end else if (s_axi_araddr[7:0] == cioc_pkg::A_SSI) begin
        s_axi_rdata <= 32'(ssi_pos_r);
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= cioc_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // analogue filters
  // ------------------------------------------------------------
  logic [15:0] ain_s [4];
  assign ain_s[0] = {ain0, 6'h00};
  assign ain_s[1] = {ain1, 6'h00};
  assign ain_s[2] = ain2;
  assign ain_s[3] = ain3;

  // a 16-bit sample widened to 21 bits; factor 0..15, shift right by it
  for (genvar i = 0; i < cioc_pkg::AIN_N; i++) begin : g_filt
    logic [20:0] acc_r;
    logic signed [21:0] diff;
    assign diff = $signed({1'b0, ain_s[i], 5'h00}) - $signed({1'b0, acc_r});
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        acc_r <= 21'h0;
      end else if (ain_strobe) begin
        acc_r <= 21'(acc_r + 21'(diff >>> filt_r[4*i +: 4]));
      end
    end
    assign filt_q[i] = acc_r[20:5];
  end

  // ------------------------------------------------------------
  // routing, command and feedback selection
  // ------------------------------------------------------------
  logic [15:0] cmd_v, fb_v;
  logic [3:0]  isig;
  logic [3:0]  din_eff;
  logic        remote;
  assign remote = ctrl_r[cioc_pkg::C_REMOTE];
  assign cmd_v = filt_q[route_r[1:0]];
  assign fb_v = filt_q[route_r[3:2]];
  assign ch_cmd = remote ? remcmd_r[15:0] : cmd_v;
  assign ch_fb = fb_v;

  for (genvar d = 0; d < cioc_pkg::DIN_N; d++) begin : g_din
    // route bit selects internal signal instead of the pin
    assign din_eff[d] = route_r[8 + d] ? isig[d] : din[d];
  end
  assign ch_din[0] = din_eff[route_r[13:12]];
  assign ch_din[1] = din_eff[route_r[15:14]];

  // ------------------------------------------------------------
  // break detection
  // ------------------------------------------------------------
  logic [31:0] brk_cnt_r [2];
  logic [1:0]  err_r;
  logic [1:0]  bad, arm;
  cioc_pkg::cioc_sig_t typ [2];
  assign typ[0] = cioc_pkg::cioc_sig_t'(ctrl_r[cioc_pkg::C_TYPE_CMD_LSB +: 3]);
  assign typ[1] = cioc_pkg::cioc_sig_t'(ctrl_r[cioc_pkg::C_TYPE_FB_LSB +: 3]);
  assign arm[0] = typ[0] != cioc_pkg::CIOC_SIG_OFF && typ[0] <= cioc_pkg::CIOC_SIG_PWM
      && ctrl_r[cioc_pkg::C_BRK_ON_CMD] && ctrl_r[cioc_pkg::C_ACT_CMD]
      && brk_cmd_r.hi > brk_cmd_r.lo;
  assign arm[1] = typ[1] != cioc_pkg::CIOC_SIG_OFF && typ[1] <= cioc_pkg::CIOC_SIG_PWM
      && ctrl_r[cioc_pkg::C_BRK_ON_FB] && ctrl_r[cioc_pkg::C_ACT_FB]
      && brk_fb_r.hi > brk_fb_r.lo;
  assign bad[0] = arm[0] && (cmd_v < brk_cmd_r.lo || cmd_v > brk_cmd_r.hi);
  assign bad[1] = arm[1] && (fb_v < brk_fb_r.lo || fb_v > brk_fb_r.hi);

  for (genvar b = 0; b < 2; b++) begin : g_brk
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        brk_cnt_r[b] <= 32'h0;
        err_r[b] <= 1'b0;
      end else if (!bad[b]) begin
        brk_cnt_r[b] <= 32'h0;
        err_r[b] <= 1'b0;
      end else if (brk_cnt_r[b] < 32'(BRK_CYC - 1)) begin
        brk_cnt_r[b] <= brk_cnt_r[b] + 32'h1;
      end else begin
        err_r[b] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // ssi master at 300 kHz
  // ------------------------------------------------------------
  cioc_pkg::cioc_ssi_t ssi_st_r;
  logic [15:0] ssi_div_r;
  logic [7:0]  ssi_bit_r;
  logic [SSI_BITS-1:0] ssi_sh_r;
  logic        ssi_done;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ssi_st_r <= cioc_pkg::CIOC_SSI_IDLE;
      ssi_div_r <= 16'h0;
      ssi_bit_r <= 8'h0;
      ssi_sh_r <= '0;
      ssi_pos_r <= '0;
      ssi_clk <= 1'b1;
    end else if (ssi_div_r != 16'(cioc_pkg::SSI_HALF_CYC - 1)) begin
      ssi_div_r <= ssi_div_r + 16'h1;
    end else begin
      ssi_div_r <= 16'h0;
      case (ssi_st_r)
        cioc_pkg::CIOC_SSI_IDLE: begin
          ssi_st_r <= cioc_pkg::CIOC_SSI_SHIFT;
          ssi_bit_r <= 8'h0;
          ssi_clk <= 1'b0;
        end
        cioc_pkg::CIOC_SSI_SHIFT: begin
          ssi_clk <= ~ssi_clk;
          if (!ssi_clk) begin
            ssi_sh_r <= {ssi_sh_r[SSI_BITS-2:0], ssi_data};
            ssi_bit_r <= ssi_bit_r + 8'h1;
            if (ssi_bit_r == 8'(SSI_BITS - 1)) begin
              ssi_st_r <= cioc_pkg::CIOC_SSI_PAUSE;
            end
          end
        end
        default: begin
          ssi_clk <= 1'b1;
          ssi_pos_r <= ssi_sh_r;
          ssi_st_r <= cioc_pkg::CIOC_SSI_IDLE;
        end
      endcase
    end
  end
  assign ssi_done = ssi_st_r == cioc_pkg::CIOC_SSI_PAUSE
      && ssi_div_r == 16'(cioc_pkg::SSI_HALF_CYC - 1);
  assign ev_set = {ssi_done, err_r[1], err_r[0]};

  // ------------------------------------------------------------
  // solenoid pwm with dither and optional current loop
  // ------------------------------------------------------------
  logic [15:0] pwm_cnt_r;
  logic [7:0]  dith_cnt_r;
  logic [15:0] duty_r [2];
  logic [15:0] sol_cur [2];
  logic [31:0] sol_cfg [2];
  assign sol_cur[0] = sol_cur0;
  assign sol_cur[1] = sol_cur1;
  assign sol_cfg[0] = sol0_r;
  assign sol_cfg[1] = sol1_r;

  // sol cfg: [15:0] setpoint (duty or current), [23:16] dither amplitude
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_cnt_r <= 16'h0;
      dith_cnt_r <= 8'h0;
    end else if (pwm_cnt_r == 16'(PWM_CYC - 1)) begin
      pwm_cnt_r <= 16'h0;
      dith_cnt_r <= dith_cnt_r + 8'h1;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 16'h1;
    end
  end

  for (genvar s = 0; s < 2; s++) begin : g_sol
    logic [15:0] base, dith;
    assign dith = dith_cnt_r[3] ? {8'h00, sol_cfg[s][23:16]} : 16'h0;
    always_comb begin
      if (!ctrl_r[cioc_pkg::C_CURMEAS]) begin
        base = sol_cfg[s][15:0];
      end else if (sol_cur[s] < sol_cfg[s][15:0] && duty_r[s] != 16'hFFFF) begin
        base = duty_r[s] + 16'h1;
      end else if (sol_cur[s] > sol_cfg[s][15:0] && duty_r[s] != 16'h0000) begin
        base = duty_r[s] - 16'h1;
      end else begin
        base = duty_r[s];
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        duty_r[s] <= 16'h0;
        sol_pwm[s] <= 1'b0;
      end else if (!ctrl_r[cioc_pkg::C_CH_EN0 + s]) begin
        duty_r[s] <= 16'h0;
        sol_pwm[s] <= 1'b0;
      end else begin
        if (pwm_cnt_r == 16'(PWM_CYC - 1)) begin
          duty_r[s] <= base;
        end
        sol_pwm[s] <= pwm_cnt_r < duty_r[s] + dith;
      end
    end
  end

  // ------------------------------------------------------------
  // digital and analogue outputs
  // ------------------------------------------------------------
  // dout cfg per output: [1:0] 0 function,1 force0,2 force1; [3:2] function source
  logic [3:0] dfunc;
  assign dfunc = {err_r[1], err_r[0], sol_pwm[1] | sol_pwm[0], remote};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout <= 4'h0;
      isig <= 4'h0;
      aout <= 16'h0;
    end else begin
      for (int k = 0; k < cioc_pkg::DOUT_N; k++) begin
        logic v;
        v = dfunc[dout_r[4*k+2 +: 2]];
        if (dout_r[4*k +: 2] == 2'h1) begin
          v = 1'b0;
        end else if (dout_r[4*k +: 2] == 2'h2) begin
          v = 1'b1;
        end
        if (dout_r[16 + k]) begin
          isig[k] <= v;
        end else begin
          dout[k] <= v;
        end
      end
      case (cioc_pkg::cioc_aosel_t'(ctrl_r[cioc_pkg::C_AOSEL_LSB +: 2]))
        cioc_pkg::CIOC_AO_DRV: aout <= duty_r[0];
        cioc_pkg::CIOC_AO_CMD: aout <= ch_cmd;
        cioc_pkg::CIOC_AO_FB: aout <= ctrl_r[cioc_pkg::C_CLOSED] ? ch_fb : 16'h0;
        default: aout <= ctrl_r[cioc_pkg::C_CLOSED] ? 16'(ch_cmd - ch_fb) : 16'h0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_dis_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl_r[cioc_pkg::C_CH_EN0] |=> !sol_pwm[0])
    else $error("disabled channel drives solenoid");
  chk_brk_early: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(bad[0]) |-> !err_r[0] [*8])
    else $error("break reported too early");
  chk_brk_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      !bad[0] |=> !err_r[0])
    else $error("break error without fault");
  chk_err_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
      err_r[1] |=> stat_r[cioc_pkg::S_ERR_FB])
    else $error("feedback break not latched");
  chk_arm_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl_r[cioc_pkg::C_BRK_ON_CMD] |-> !bad[0])
    else $error("break checked while switched off");
  chk_remote_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
      remote |-> ch_cmd == remcmd_r[15:0])
    else $error("remote command not used");
  chk_force_high: assert property (@(posedge aclk) disable iff (!aresetn)
      dout_r[1:0] == 2'h2 && !dout_r[16] && $stable(dout_r) |=> dout[0])
    else $error("forced output not high");
  chk_pwm_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
      pwm_cnt_r == 16'(PWM_CYC - 1) |=> pwm_cnt_r == 16'h0)
    else $error("pwm period wrong");
endmodule
`default_nettype wire

/* verification/channel_io_conditioning_tb.sv */
// testbench: register bus, filters, break check, pwm, digital and serial outputs
`timescale 1ns/1ps
`default_nettype none
module channel_io_conditioning_tb;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
  logic        ain_strobe = 0, ssi_data, ssi_clk, irq;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, sol_pwm, ch_din, rs;
  logic [9:0]  ain0 = 0, ain1 = 0;
  logic [15:0] ain2 = 0, ain3 = 0, sol_cur0 = 0, sol_cur1 = 0, aout, ch_cmd, ch_fb;
  logic [3:0]  din = 0, dout;
  integer      seed = 32'hE0DB;
  int          error_cnt = 0, cmp_count = 0, n, acc[4], fac[4];
  logic [15:0] v[4];
  cioc_top #(.BRK_CYC(20), .PWM_CYC(16)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .ain0,
    .ain1, .ain2, .ain3, .ain_strobe, .din, .sol_cur0, .sol_cur1, .ssi_data, .ssi_clk,
    .sol_pwm, .dout, .aout, .ch_din, .ch_cmd, .ch_fb, .irq);
  cioc_ssi_sensor sens (.ssi_clk, .ssi_data);
  initial forever #20 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  // one converter sample on all inputs, model filter follows with five fraction bits
  task automatic smp(input logic [15:0] a, input logic [15:0] b);
    ain0 <= a[9:0];
    ain1 <= b[9:0];
    ain2 <= a;
    ain3 <= b;
    ain_strobe <= 1'b1;
    v[0] = {a[9:0], 6'h00};
    v[1] = {b[9:0], 6'h00};
    v[2] = a;
    v[3] = b;
    for (int i = 0; i < 4; i++) acc[i] = acc[i] + ((int'(v[i]) * 32 - acc[i]) >>> fac[i]);
    @(posedge aclk);
    ain_strobe <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    acc = '{0, 0, 0, 0};
    fac = '{2, 0, 4, 0};
    din <= 4'($random(seed)) & 4'hE;
    sol_cur0 <= 16'($random(seed));
    sol_cur1 <= 16'($random(seed));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(cioc_pkg::A_CTRL);
    chk("ctrl reset", rd, cioc_pkg::CTRL_RST);
    rdr(8'hF0);
    chk("unmapped read", rd, 32'h0);
    chk("unmapped resp", rs, cioc_pkg::RESP_SLVERR);
    wr(8'hF4, 32'h1);
    chk("unmapped write", rs, cioc_pkg::RESP_SLVERR);
    wr(cioc_pkg::A_FILT, 32'h0000_0402);
    v[0] = $random(seed);
    v[1] = $random(seed);
    n = v[0];
    // constant a stream: filters 0 and 2 climb from zero with no negative step
    repeat (3) smp(n[15:0], v[1]);
    rdr(cioc_pkg::A_AIN01);
    chk("filter 0 1", rd, {acc[1][20:5], acc[0][20:5]});
    rdr(cioc_pkg::A_AIN23);
    chk("filter 2 3", rd, {acc[3][20:5], acc[2][20:5]});
    fac = '{0, 0, 0, 0};
    wr(cioc_pkg::A_FILT, 32'h0);
    wr(cioc_pkg::A_BRK_CMD, 32'h1000_F000);
    wr(cioc_pkg::A_BRK_FB, 32'h1000_F000);
    wr(cioc_pkg::A_ROUTE, 32'h0000_0004);
    wr(cioc_pkg::A_IRQ_EN, 32'h3);
    wr(cioc_pkg::A_CTRL, 32'h0000_9078);
    for (int k = 0; k < 2; k++) begin
      smp((k == 0) ? 16'h0 : 16'h200, (k == 1) ? 16'h3FF : 16'h200);
      repeat (5) @(posedge aclk);
      rdr(cioc_pkg::A_STAT);
      chk("break early", rd & 32'h3, 32'h0);
      repeat (30) @(posedge aclk);
      rdr(cioc_pkg::A_STAT);
      chk("break flag", rd & 32'h3, 32'h1 << k);
      chk("irq on", irq, 1'b1);
      smp(16'h200, 16'h200);
      wr(cioc_pkg::A_IRQ_CLR, 32'h3);
      rdr(cioc_pkg::A_STAT);
      chk("break clear", rd & 32'h3, 32'h0);
      chk("irq off", irq, 1'b0);
    end
    wr(cioc_pkg::A_CTRL, 32'h0000_9070);
    smp(16'h0, 16'h200);
    repeat (40) @(posedge aclk);
    rdr(cioc_pkg::A_STAT);
    chk("break off", rd & 32'h3, 32'h0);
    smp(16'h200, 16'h200);
    wr(cioc_pkg::A_DOUT, 32'h0000_1212);
    repeat (3) @(posedge aclk);
    chk("dout forced", dout, 4'b0101);
    n = $random(seed);
    wr(cioc_pkg::A_REM_CMD, n);
    wr(cioc_pkg::A_ROUTE, 32'h0000_C104);
    wr(cioc_pkg::A_DOUT, 32'h0001_0002);
    wr(cioc_pkg::A_CTRL, 32'h0000_0201);
    repeat (2) @(posedge aclk);
    chk("remote cmd", ch_cmd, n[15:0]);
    chk("aout cmd", aout, n[15:0]);
    chk("fb route", ch_fb, 16'h8000);
    chk("din route", ch_din, {din[3], 1'b1});
    chk("dout func", dout, 4'hF);
    wr(cioc_pkg::A_CTRL, 32'h0000_0400);
    repeat (2) @(posedge aclk);
    chk("aout fb open", aout, 16'h0);
    wr(cioc_pkg::A_CTRL, 32'h0000_0500);
    repeat (2) @(posedge aclk);
    chk("aout fb", aout, 16'h8000);
    chk("local cmd", ch_cmd, 16'h8000);
    wr(cioc_pkg::A_SOL0, 32'h0000_0004);
    for (int e = 0; e < 2; e++) begin
      if (e == 1) wr(cioc_pkg::A_CTRL, 32'h0000_9072);
      repeat (32) @(posedge aclk);
      n = 0;
      repeat (48) begin
        @(posedge aclk);
        n += sol_pwm[0];
      end
      chk("pwm highs", n, (e == 0) ? 0 : 12);
    end
    wr(cioc_pkg::A_IRQ_CLR, 32'h4);
    n = 0;
    do begin
      repeat (10) @(posedge aclk);
      rdr(cioc_pkg::A_STAT);
      n++;
    end while (rd[cioc_pkg::S_SSI_DONE] !== 1'b1 && n < 400);
    chk("ssi frame", rd[cioc_pkg::S_SSI_DONE], 1'b1);
    rdr(cioc_pkg::A_SSI);
    chk("ssi position", rd, 32'h00A5_3C96);
    tally_and_finish;
  end
endmodule
`default_nettype wire

/* verification/cioc_ssi_sensor.sv */
// position sensor model on the synchronous serial link
`timescale 1ns/1ps
`default_nettype none
module cioc_ssi_sensor #(
  parameter logic [23:0] POS = 24'hA53C96
) (
  input  wire logic ssi_clk,
  output logic      ssi_data
);
  int k = 0;
  initial ssi_data = 1'b1;
  // next bit msb first on each falling clock edge
  always @(negedge ssi_clk) begin
    ssi_data = POS[23-k];
    k = (k == 23) ? 0 : k + 1;
  end
  // line released after the frame: pulled high
  always @(posedge ssi_clk) begin
    if (k == 0) ssi_data = 1'b1;
  end
endmodule
`default_nettype wire
